/* mni_pkg.sv */
// constants and types shared by the main-node serial relay target
package mni_pkg;

  // ************************************************************
  // target address and register map
  // ************************************************************
  localparam logic [3:0] ADDR_PREFIX = 4'hd; // upper four address bits 1101
  localparam logic [7:0] NODE_SELECT_OFFSET = 8'h01;
  localparam logic [7:0] SERIAL_PORT_CONFIG_OFFSET = 8'h02;
  localparam logic [7:0] SLOT_FORMAT_OFFSET = 8'h10;
  localparam logic [7:0] DATA_CONTROL_OFFSET = 8'h11;
  localparam logic [7:0] SERIAL_RATE_OFFSET = 8'h12;
  localparam logic [7:0] NODE_SELECT_RESET = 8'h00;
  localparam logic [7:0] SERIAL_PORT_CONFIG_RESET = 8'h00;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int NODE_IDX_LSB = 0;
  localparam int NODE_IDX_WIDTH = 4;
  localparam int PERI_BIT = 5;
  localparam int BRCST_BIT = 7;
  localparam int EACK_BIT = 0;
  localparam logic [7:0] READ_FAIL_DATA = 8'hff; // returned for a failed relayed read after the first byte of a burst

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLOCK_NS = 25;
  localparam int SCL_MAX_KHZ = 1000;
  localparam int SCL_MIN_HALF_NS = 1000000 / SCL_MAX_KHZ / 2;
  localparam int SCL_MIN_HALF_CYC = SCL_MIN_HALF_NS / CLOCK_NS; // rounded down, well above sync latency
  localparam logic [4:0] SF_TIMEOUT = 5'h1e; // 30 superframes

  // ************************************************************
  // state types
  // ************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK = 3'b010,
    ST_RX = 3'b011,
    ST_STRETCH = 3'b100,
    ST_TX = 3'b101,
    ST_RACK = 3'b110
  } mni_state_t;

  typedef enum logic [1:0] {
    RL_IDLE = 2'b00,
    RL_PEND = 2'b01,
    RL_WAIT = 2'b10
  } mni_relay_t;

  typedef enum logic [1:0] {
    SK_WRITE = 2'b00,
    SK_READ_FIRST = 2'b01,
    SK_READ_NEXT = 2'b10
  } mni_stretch_t;

endpackage

/* mni_relay_target.sv */
// serial target of the main node with relay of bus-address accesses over the chain
`timescale 1ns/10ps
`default_nettype none

module mni_relay_target (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic scl_in,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_oe,
  input wire logic address_strap_low,
  input wire logic address_strap_high,
  input wire logic sf_control_start,
  input wire logic rf_valid,
  input wire logic rf_ok,
  input wire logic [7:0] rf_data,
  output logic cf_valid,
  output logic cf_write,
  output logic cf_broadcast,
  output logic cf_peripheral,
  output logic [mni_pkg::NODE_IDX_WIDTH-1:0] cf_node,
  output logic [7:0] cf_reg,
  output logic [7:0] cf_data,
  output logic [7:0] local_addr,
  input wire logic [7:0] local_rdata,
  output logic local_wr_en,
  output logic [7:0] local_wr_addr,
  output logic [7:0] local_wr_data,
  output logic serial_access_error_flag,
  input wire logic error_clear
);
  import mni_pkg::*;

  logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
  logic [1:0] strap_s1, strap_s2, strap_reg;
  logic strap_done_reg;
  logic [1:0] strap_wait_reg;
  logic scl_rise, scl_fall, start_cond, stop_cond;
  mni_state_t state_reg;
  mni_stretch_t kind_reg;
  mni_relay_t rly_state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg, ptr_reg, tx_reg;
  logic is_bus_reg, is_read_reg, first_reg, host_ack_reg, launched_reg, eack_mode_reg;
  logic scl_oe_reg, sda_oe_reg;
  logic wr_en_reg;
  logic [7:0] wr_addr_reg, wr_data_reg;
  logic [7:0] node_select_reg, serial_port_config_reg;
  logic rly_go_reg, rq_write_reg, rq_bcast_reg;
  logic [7:0] rq_reg_reg, rq_data_reg;
  logic cf_valid_reg, cf_write_reg, cf_bcast_reg, cf_peri_reg;
  logic [NODE_IDX_WIDTH-1:0] cf_node_reg;
  logic [7:0] cf_reg_reg, cf_data_reg;
  logic [4:0] sf_cnt_reg;
  logic rly_done_reg, rly_ok_reg;
  logic [7:0] rly_rdata_reg;
  logic err_reg;
  logic rly_busy, addr_match;
  logic [7:0] rd_byte;

  // ************************************************************
  // helper functions
  // ************************************************************
  // registers whose writes are copied to every discovered node
  function automatic logic is_auto_bcast(input logic [7:0] a);
    return (a == SLOT_FORMAT_OFFSET) || (a == DATA_CONTROL_OFFSET) || (a == SERIAL_RATE_OFFSET);
  endfunction

  // read mux: own registers first, then the rest of the device
  function automatic logic [7:0] local_read(input logic [7:0] a, input logic [7:0] ext);
    if (a == NODE_SELECT_OFFSET) begin
      return node_select_reg;
    end
    if (a == SERIAL_PORT_CONFIG_OFFSET) begin
      return serial_port_config_reg;
    end
    return ext;
  endfunction

  // ************************************************************
  // pin synchronisers and strap capture
  // ************************************************************
  // three flops per bus pin, two per strap pin; edge detect looks only at second and third stage
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_s3 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
      strap_s1 <= 2'h0;
      strap_s2 <= 2'h0;
    end else begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
      strap_s1 <= {address_strap_high, address_strap_low};
      strap_s2 <= strap_s1;
    end
  end

  // straps caught once, after the synchroniser has filled with pin levels
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      strap_reg <= 2'h0;
      strap_done_reg <= 1'b0;
      strap_wait_reg <= 2'h0;
    end else if (!strap_done_reg) begin
      if (strap_wait_reg == 2'h2) begin
        strap_reg <= strap_s2;
        strap_done_reg <= 1'b1;
      end else begin
        strap_wait_reg <= strap_wait_reg + 2'h1;
      end
    end
  end

  // sampling at 40 MHz leaves many cycles per half period at 1 MHz
  assign scl_rise = scl_s2 && !scl_s3;
  assign scl_fall = !scl_s2 && scl_s3;
  assign start_cond = scl_s2 && scl_s3 && sda_s3 && !sda_s2;
  assign stop_cond = scl_s2 && scl_s3 && !sda_s3 && sda_s2;
  assign addr_match = strap_done_reg && (shift_reg[7:2] == {ADDR_PREFIX, strap_reg});
  assign rly_busy = (rly_state_reg != RL_IDLE) || rly_go_reg;
  assign rd_byte = local_read(ptr_reg, local_rdata);

  // ************************************************************
  // serial target state machine
  // ************************************************************
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
      kind_reg <= SK_WRITE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      tx_reg <= 8'h00;
      is_bus_reg <= 1'b0;
      is_read_reg <= 1'b0;
      first_reg <= 1'b0;
      host_ack_reg <= 1'b0;
      launched_reg <= 1'b0;
      eack_mode_reg <= 1'b0;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      wr_en_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      wr_data_reg <= 8'h00;
      rly_go_reg <= 1'b0;
      rq_write_reg <= 1'b0;
      rq_bcast_reg <= 1'b0;
      rq_reg_reg <= 8'h00;
      rq_data_reg <= 8'h00;
    end else begin
      wr_en_reg <= 1'b0;
      rly_go_reg <= 1'b0;
      if (start_cond) begin
        state_reg <= ST_ADDR;
        bit_cnt_reg <= 4'h0;
        scl_oe_reg <= 1'b0;
        sda_oe_reg <= 1'b0;
      end else if (stop_cond) begin
        state_reg <= ST_IDLE;
        scl_oe_reg <= 1'b0;
        sda_oe_reg <= 1'b0;
      end else begin
        unique case (state_reg)
          ST_IDLE: begin
            scl_oe_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
          end
          ST_ADDR, ST_RX: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_s2};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && bit_cnt_reg == 4'h8) begin
              if (state_reg == ST_ADDR) begin
                is_bus_reg <= shift_reg[1];
                is_read_reg <= shift_reg[0];
                first_reg <= !shift_reg[0];
                if (!addr_match) begin
                  state_reg <= ST_IDLE;
                end else if (shift_reg[1] && shift_reg[0]) begin
                  // relayed read fetched before the address ack so a failure can nak
                  rq_write_reg <= 1'b0;
                  rq_bcast_reg <= 1'b0;
                  rq_reg_reg <= ptr_reg;
                  kind_reg <= SK_READ_FIRST;
                  eack_mode_reg <= 1'b0;
                  launched_reg <= 1'b0;
                  scl_oe_reg <= 1'b1;
                  state_reg <= ST_STRETCH;
                end else begin
                  sda_oe_reg <= 1'b1;
                  state_reg <= ST_ACK;
                  if (shift_reg[0]) begin
                    tx_reg <= rd_byte;
                    ptr_reg <= ptr_reg + 8'h01;
                  end
                end
              end else if (first_reg) begin
                ptr_reg <= shift_reg;
                first_reg <= 1'b0;
                sda_oe_reg <= 1'b1;
                state_reg <= ST_ACK;
              end else if (is_bus_reg) begin
                // no arbitration with local writes at the subordinate; both land
                rq_write_reg <= 1'b1;
                rq_bcast_reg <= node_select_reg[BRCST_BIT];
                rq_reg_reg <= ptr_reg;
                rq_data_reg <= shift_reg;
                ptr_reg <= ptr_reg + 8'h01;
                wr_en_reg <= node_select_reg[BRCST_BIT];
                wr_addr_reg <= ptr_reg;
                wr_data_reg <= shift_reg;
                kind_reg <= SK_WRITE;
                eack_mode_reg <= serial_port_config_reg[EACK_BIT];
                launched_reg <= 1'b0;
                scl_oe_reg <= 1'b1;
                state_reg <= ST_STRETCH;
              end else begin
                wr_en_reg <= 1'b1;
                wr_addr_reg <= ptr_reg;
                wr_data_reg <= shift_reg;
                ptr_reg <= ptr_reg + 8'h01;
                if (is_auto_bcast(ptr_reg)) begin
                  rq_write_reg <= 1'b1;
                  rq_bcast_reg <= 1'b1;
                  rq_reg_reg <= ptr_reg;
                  rq_data_reg <= shift_reg;
                  kind_reg <= SK_WRITE;
                  eack_mode_reg <= 1'b0;
                  launched_reg <= 1'b0;
                  scl_oe_reg <= 1'b1;
                  state_reg <= ST_STRETCH;
                end else begin
                  sda_oe_reg <= 1'b1;
                  state_reg <= ST_ACK;
                end
              end
            end
          end
          ST_STRETCH: begin
            // hold the clock low; host must wait for the chain, or with early ack for a bus-address write only until the request is launched
            scl_oe_reg <= 1'b1;
            if (!launched_reg) begin
              if (!rly_busy) begin
                rly_go_reg <= 1'b1;
                launched_reg <= 1'b1;
              end
            end else if (eack_mode_reg && kind_reg == SK_WRITE) begin
              sda_oe_reg <= 1'b1;
              state_reg <= ST_ACK;
            end else if (rly_done_reg) begin
              unique case (kind_reg)
                SK_WRITE: begin
                  sda_oe_reg <= rly_ok_reg;
                  state_reg <= rly_ok_reg ? ST_ACK : ST_IDLE;
                end
                SK_READ_FIRST: begin
                  tx_reg <= rly_rdata_reg;
                  ptr_reg <= ptr_reg + 8'h01;
                  sda_oe_reg <= rly_ok_reg;
                  state_reg <= rly_ok_reg ? ST_ACK : ST_IDLE;
                end
                SK_READ_NEXT: begin
                  tx_reg <= rly_ok_reg ? rly_rdata_reg : READ_FAIL_DATA;
                  ptr_reg <= ptr_reg + 8'h01;
                  sda_oe_reg <= rly_ok_reg ? !rly_rdata_reg[7] : !READ_FAIL_DATA[7];
                  bit_cnt_reg <= 4'h0;
                  state_reg <= ST_TX;
                end
                default: state_reg <= ST_IDLE;
              endcase
            end
          end
          ST_ACK: begin
            scl_oe_reg <= 1'b0;
            if (scl_fall) begin
              bit_cnt_reg <= 4'h0;
              if (is_read_reg) begin
                sda_oe_reg <= !tx_reg[7];
                state_reg <= ST_TX;
              end else begin
                sda_oe_reg <= 1'b0;
                state_reg <= ST_RX;
              end
            end
          end
          ST_TX: begin
            scl_oe_reg <= 1'b0;
            if (scl_fall) begin
              if (bit_cnt_reg == 4'h7) begin
                sda_oe_reg <= 1'b0;
                state_reg <= ST_RACK;
              end else begin
                tx_reg <= {tx_reg[6:0], 1'b0};
                sda_oe_reg <= !tx_reg[6];
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              host_ack_reg <= !sda_s2;
            end else if (scl_fall) begin
              if (!host_ack_reg) begin
                state_reg <= ST_IDLE;
              end else if (is_bus_reg) begin
                rq_write_reg <= 1'b0;
                rq_bcast_reg <= 1'b0;
                rq_reg_reg <= ptr_reg;
                kind_reg <= SK_READ_NEXT;
                eack_mode_reg <= 1'b0;
                launched_reg <= 1'b0;
                scl_oe_reg <= 1'b1;
                state_reg <= ST_STRETCH;
              end else begin
                tx_reg <= rd_byte;
                sda_oe_reg <= !rd_byte[7];
                ptr_reg <= ptr_reg + 8'h01;
                bit_cnt_reg <= 4'h0;
                state_reg <= ST_TX;
              end
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // ************************************************************
  // own registers
  // ************************************************************
  // written from base-address or broadcast writes only; otherwise held
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      node_select_reg <= NODE_SELECT_RESET;
      serial_port_config_reg <= SERIAL_PORT_CONFIG_RESET;
    end else if (wr_en_reg) begin
      if (wr_addr_reg == NODE_SELECT_OFFSET) begin
        node_select_reg <= wr_data_reg;
      end
      if (wr_addr_reg == SERIAL_PORT_CONFIG_OFFSET) begin
        serial_port_config_reg <= wr_data_reg;
      end
    end
  end

  // ************************************************************
  // chain relay engine
  // ************************************************************
  // request waits for the next control field, then for a response or timeout
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rly_state_reg <= RL_IDLE;
      sf_cnt_reg <= 5'h00;
      cf_valid_reg <= 1'b0;
      cf_write_reg <= 1'b0;
      cf_bcast_reg <= 1'b0;
      cf_peri_reg <= 1'b0;
      cf_node_reg <= '0;
      cf_reg_reg <= 8'h00;
      cf_data_reg <= 8'h00;
      rly_done_reg <= 1'b0;
      rly_ok_reg <= 1'b0;
      rly_rdata_reg <= 8'h00;
    end else begin
      cf_valid_reg <= 1'b0;
      rly_done_reg <= 1'b0;
      unique case (rly_state_reg)
        RL_IDLE: begin
          sf_cnt_reg <= 5'h00;
          if (rly_go_reg) begin
            rly_state_reg <= RL_PEND;
          end
        end
        RL_PEND: begin
          if (sf_control_start) begin
            cf_valid_reg <= 1'b1;
            cf_write_reg <= rq_write_reg;
            cf_bcast_reg <= rq_bcast_reg && rq_write_reg;
            cf_peri_reg <= node_select_reg[PERI_BIT];
            cf_node_reg <= node_select_reg[NODE_IDX_LSB +: NODE_IDX_WIDTH];
            cf_reg_reg <= rq_reg_reg;
            cf_data_reg <= rq_data_reg;
            sf_cnt_reg <= 5'h01;
            rly_state_reg <= RL_WAIT;
          end
        end
        RL_WAIT: begin
          if (rf_valid) begin
            rly_done_reg <= 1'b1;
            rly_ok_reg <= rf_ok;
            rly_rdata_reg <= rf_data;
            rly_state_reg <= RL_IDLE;
          end else if (sf_control_start) begin
            if (sf_cnt_reg == SF_TIMEOUT) begin
              rly_done_reg <= 1'b1;
              rly_ok_reg <= 1'b0;
              rly_state_reg <= RL_IDLE;
            end else begin
              sf_cnt_reg <= sf_cnt_reg + 5'h01;
            end
          end
        end
        default: rly_state_reg <= RL_IDLE;
      endcase
    end
  end

  // sticky error; a new failure wins over a clear in the same cycle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      err_reg <= 1'b0;
    end else if (rly_done_reg && !rly_ok_reg) begin
      err_reg <= 1'b1;
    end else if (error_clear) begin
      err_reg <= 1'b0;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign scl_oe = scl_oe_reg;
  assign sda_oe = sda_oe_reg;
  assign cf_valid = cf_valid_reg;
  assign cf_write = cf_write_reg;
  assign cf_broadcast = cf_bcast_reg;
  assign cf_peripheral = cf_peri_reg;
  assign cf_node = cf_node_reg;
  assign cf_reg = cf_reg_reg;
  assign cf_data = cf_data_reg;
  assign local_addr = ptr_reg;
  assign local_wr_en = wr_en_reg;
  assign local_wr_addr = wr_addr_reg;
  assign local_wr_data = wr_data_reg;
  assign serial_access_error_flag = err_reg;

  // ************************************************************
  // assertions
  // ************************************************************
  sequence s_fail_done;
    rly_done_reg && !rly_ok_reg;
  endsequence

  a_cf_at_frame: assert property (@(posedge clock) disable iff (!arst_n)
    cf_valid_reg |-> $past(sf_control_start) && $past(rly_state_reg) == RL_PEND)
    else $error("control field request issued outside a control field start");
  a_bcast_write_only: assert property (@(posedge clock) disable iff (!arst_n)
    cf_valid_reg && cf_bcast_reg |-> cf_write_reg)
    else $error("broadcast on a read request");
  a_timeout_bound: assert property (@(posedge clock) disable iff (!arst_n)
    rly_state_reg == RL_WAIT |-> sf_cnt_reg <= SF_TIMEOUT)
    else $error("superframe wait passed the timeout");
  a_fail_nak: assert property (@(posedge clock) disable iff (!arst_n)
    ((state_reg == ST_STRETCH && kind_reg == SK_WRITE && !eack_mode_reg && launched_reg
    && !start_cond && !stop_cond) and s_fail_done) |=> !sda_oe_reg && state_reg == ST_IDLE)
    else $error("failed relayed write was not answered with nak");
  a_err_set: assert property (@(posedge clock) disable iff (!arst_n)
    s_fail_done |=> err_reg)
    else $error("error flag not raised after failed relay");
  a_stretch_hold: assert property (@(posedge clock) disable iff (!arst_n)
    state_reg == ST_STRETCH && launched_reg && !eack_mode_reg && !rly_done_reg && !start_cond
    && !stop_cond |=> scl_oe_reg && state_reg == ST_STRETCH)
    else $error("clock released before relay completed");
  a_bcast_local: assert property (@(posedge clock) disable iff (!arst_n)
    state_reg == ST_RX && scl_fall && bit_cnt_reg == 4'h8 && !first_reg && is_bus_reg
    && node_select_reg[BRCST_BIT] && !start_cond && !stop_cond |=> wr_en_reg && state_reg == ST_STRETCH)
    else $error("broadcast write missed the local copy");
  a_node_persist: assert property (@(posedge clock) disable iff (!arst_n)
    !$stable(node_select_reg) |-> $past(wr_en_reg) && $past(wr_addr_reg) == NODE_SELECT_OFFSET)
    else $error("node selection changed without a write");
  a_ptr_advance: assert property (@(posedge clock) disable iff (!arst_n)
    wr_en_reg && !is_bus_reg |-> ptr_reg == wr_addr_reg + 8'h01)
    else $error("pointer did not advance after a data byte");

endmodule // mni_relay_target

`default_nettype wire

/* mni_host_model.sv */
// serial bus controller model for the host side
`timescale 1ns/10ps
`default_nettype none
module mni_host_model (
  input wire logic clock,
  input wire logic scl,
  input wire logic sda,
  output logic scl_low,
  output logic sda_low
);
  int half = 20; // 500 ns phase, 1 MHz bus
  int stalls = 0; // stretches that outlasted the wait limit
  // both lines released at start
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // one bit, waiting out stretching by the target
  task automatic bit_io(input logic b, output logic r);
    int k;
    sda_low = !b;
    tick(half);
    scl_low = 1'b0;
    k = 0;
    while (scl !== 1'b1 && k < 3000) begin
      tick(1);
      k++;
    end
    if (k >= 3000) stalls++;
    tick(half);
    r = sda;
    scl_low = 1'b1;
  endtask
  task automatic start();
    sda_low = 1'b1;
    tick(half);
    scl_low = 1'b1;
  endtask
  task automatic stop();
    sda_low = 1'b1;
    tick(half);
    scl_low = 1'b0;
    tick(half);
    sda_low = 1'b0;
    tick(half);
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // host acks every byte but the last
  task automatic recv(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(!more, r);
  endtask
endmodule // mni_host_model
`default_nettype wire

/* mni_relay_target_bench.sv */
// self-checking bench for the relay target
`timescale 1ns/10ps
`default_nettype none
module mni_relay_target_bench;
  import mni_pkg::*;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic sf_control_start = 1'b0;
  logic rf_valid = 1'b0;
  logic rf_ok = 1'b1;
  logic error_clear = 1'b0;
  logic resp_en = 1'b1;
  localparam logic [1:0] STRAPS = 2'h2;
  localparam logic [7:0] BASE_W = {ADDR_PREFIX, STRAPS, 2'h0};
  logic [1:0] straps = STRAPS;
  int writes = 0;
  logic scl_oe, sda_oe, scl_low, sda_low, cf_valid, cf_write, cf_broadcast, cf_peripheral;
  logic local_wr_en, serial_access_error_flag, ack;
  logic [3:0] cf_node;
  logic [7:0] cf_reg, cf_data, local_addr, local_wr_addr, local_wr_data, d;
  wire scl = !(scl_low || scl_oe);
  wire sda = !(sda_low || sda_oe);
  int failures = 0;
  int checked = 0;
  always #12.5 clock = !clock;
  mni_host_model host (.clock, .scl, .sda, .scl_low, .sda_low);
  mni_relay_target DUT (.clock, .arst_n, .scl_in(scl), .scl_oe, .sda_in(sda), .sda_oe,
    .address_strap_low(straps[0]), .address_strap_high(straps[1]), .sf_control_start, .rf_valid,
    .rf_ok, .rf_data(cf_reg + 8'h01), .cf_valid, .cf_write, .cf_broadcast, .cf_peripheral,
    .cf_node, .cf_reg, .cf_data, .local_addr, .local_rdata(local_addr ^ 8'h3c), .local_wr_en,
    .local_wr_addr, .local_wr_data, .serial_access_error_flag, .error_clear);
  // superframe start every 41 cycles
  always begin
    repeat (40) @(posedge clock);
    #1 sf_control_start = 1'b1;
    @(posedge clock);
    #1 sf_control_start = 1'b0;
  end
  // subordinate answers each request 8 cycles later while resp_en is set
  always @(posedge clock) begin
    if (cf_valid === 1'b1 && resp_en) begin
      repeat (8) @(posedge clock);
      #1 rf_valid = 1'b1;
      @(posedge clock);
      #1 rf_valid = 1'b0;
    end
  end
  // count local register write pulses
  always @(posedge clock) begin
    if (local_wr_en === 1'b1) writes++;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic put(input logic [7:0] b, input logic exp);
    host.send(b, ack);
    check({7'h00, ack}, {7'h00, exp});
  endtask
  // one-cycle pulse on the error clear
  task automatic clear_err();
    error_clear = 1'b1;
    host.tick(1);
    error_clear = 1'b0;
    host.tick(2);
  endtask
  task automatic summarize();
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // main sequence of bus transfers
  initial begin
    repeat (16) @(posedge clock);
    #1 arst_n = 1'b1;
    host.tick(8);
    straps = 2'h1; // pins move after the latch; address must not follow
    host.start();
    put(8'hd4, 1'b0);
    host.stop();
    host.start();
    put(BASE_W, 1'b1);
    put(NODE_SELECT_OFFSET, 1'b1);
    put(8'h03, 1'b1);
    put(8'h40, 1'b1);
    host.stop();
    check(local_wr_addr, SERIAL_PORT_CONFIG_OFFSET);
    check(local_wr_data, 8'h40);
    host.start();
    put(BASE_W, 1'b1);
    put(NODE_SELECT_OFFSET, 1'b1);
    host.stop();
    host.start();
    put(BASE_W | 8'h01, 1'b1);
    host.recv(1'b1, d);
    check(d, 8'h03);
    host.recv(1'b0, d);
    check(d, 8'h40);
    host.stop();
    host.start();
    put(BASE_W | 8'h02, 1'b1);
    put(8'h20, 1'b1);
    put(8'ha5, 1'b1);
    check({4'h0, cf_node}, 8'h03);
    check({7'h00, cf_peripheral}, 8'h00);
    check(cf_reg, 8'h20);
    check(cf_data, 8'ha5);
    check({7'h00, cf_write}, 8'h01);
    put(8'h5a, 1'b1);
    check(cf_reg, 8'h21);
    check(cf_data, 8'h5a);
    host.stop();
    rf_ok = 1'b0;
    host.start();
    put(BASE_W | 8'h02, 1'b1);
    put(8'h30, 1'b1);
    put(8'h11, 1'b0);
    host.stop();
    check({7'h00, serial_access_error_flag}, 8'h01);
    clear_err();
    check({7'h00, serial_access_error_flag}, 8'h00);
    rf_ok = 1'b1;
    resp_en = 1'b0;
    host.start();
    put(BASE_W | 8'h02, 1'b1);
    put(8'h31, 1'b1);
    put(8'h22, 1'b0);
    host.stop();
    check({7'h00, serial_access_error_flag}, 8'h01);
    clear_err();
    resp_en = 1'b1;
    // broadcast on, peripheral bit clear
    host.start();
    put(BASE_W, 1'b1);
    put(NODE_SELECT_OFFSET, 1'b1);
    put(8'h83, 1'b1);
    host.stop();
    host.start();
    put(BASE_W, 1'b1);
    put(SLOT_FORMAT_OFFSET, 1'b1);
    put(8'h12, 1'b1);
    host.stop();
    check(cf_reg, SLOT_FORMAT_OFFSET);
    check(cf_data, 8'h12);
    check({7'h00, cf_broadcast}, 8'h01);
    host.start();
    put(BASE_W | 8'h02, 1'b1);
    put(8'h40, 1'b1);
    put(8'h66, 1'b1);
    host.stop();
    check({7'h00, cf_broadcast}, 8'h01);
    check(local_wr_addr, 8'h40);
    check(local_wr_data, 8'h66);
    // relayed burst read; responder returns register number plus one
    host.start();
    put(BASE_W | 8'h03, 1'b1);
    host.recv(1'b1, d);
    check(d, 8'h42);
    check({7'h00, cf_broadcast}, 8'h00);
    check({4'h0, cf_node}, 8'h03);
    host.recv(1'b0, d);
    check(d, 8'h43);
    check({7'h00, cf_write}, 8'h00);
    host.stop();
    // peripheral target and early acknowledge
    host.start();
    put(BASE_W, 1'b1);
    put(NODE_SELECT_OFFSET, 1'b1);
    put(8'h23, 1'b1);
    put(8'h01, 1'b1);
    host.stop();
    rf_ok = 1'b0;
    host.start();
    put(BASE_W | 8'h02, 1'b1);
    put(8'h50, 1'b1);
    put(8'h77, 1'b1);
    host.stop();
    host.tick(80);
    check({7'h00, cf_peripheral}, 8'h01);
    check(cf_data, 8'h77);
    check({7'h00, serial_access_error_flag}, 8'h01);
    rf_ok = 1'b1;
    check(8'(writes), 8'h07);
    check(8'(host.stalls), 8'h00);
    summarize();
  end
  // cut a hang short
  initial begin
    #2000000;
    failures++;
    summarize();
  end
endmodule // mni_relay_target_bench
`default_nettype wire
